/* rtl/wwr_pkg.sv */
// Package: timing constants and state encodings for the window watchdog reset block
package wwr_pkg;
	// Clock rate in kHz (250 MHz reference)
	localparam int unsigned CLK_KHZ = 250000;
	// Nominal times in microseconds, fast timing
	localparam int unsigned T_SAM_US = 500;
	localparam int unsigned T_HOLD_FAST_US = 16000;
	localparam int unsigned T_SPAN_FAST_US = 32000;
	localparam int unsigned T_LONG_FAST_US = 128000;
	// Slow timing doubles every figure
	localparam int unsigned SLOW_MULT = 2;
	// Long first open span counts as this many standard open spans
	localparam int unsigned LONG_MULT = 4;
	// Sample period in clock cycles
	localparam int unsigned SAM_CYC = T_SAM_US * (CLK_KHZ / 1000);
	// Span lengths in sample ticks
	localparam int unsigned HOLD_TICKS = T_HOLD_FAST_US / T_SAM_US;
	localparam int unsigned SPAN_TICKS = T_SPAN_FAST_US / T_SAM_US;
	localparam int unsigned LONG_TICKS = T_LONG_FAST_US / T_SAM_US;
	// Counter widths
	localparam int unsigned PRE_W = 18;
	localparam int unsigned SPAN_W = 10;
	// Watchdog modes
	typedef enum logic [1:0] {
		MODE_FAST = 2'h0,
		MODE_SLOW = 2'h1,
		MODE_OFF = 2'h2
	} wwr_mode_e;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_HOLD = 3'h0,
		ST_IGNORE = 3'h1,
		ST_LONG_OPEN = 3'h2,
		ST_CLOSED = 3'h3,
		ST_OPEN = 3'h4
	} wwr_state_e;
endpackage

/* rtl/wwr_tick_if.sv */
// Interface: sample tick and trigger detection between timebase and sequencer
`timescale 1ns/100ps
`default_nettype none
interface wwr_tick_if;
	logic tick;
	logic trig;
	modport src (output tick, output trig);
	modport dst (input tick, input trig);
endinterface
`default_nettype wire

/* rtl/wwr_sampler.sv */
// Sample timebase and kick trigger detector
`timescale 1ns/100ps
`default_nettype none
module wwr_sampler #(
	// Clock cycles per fast sample period; the default is the real timebase
	parameter int unsigned SAM_CYCLES = wwr_pkg::SAM_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_slow,
	input wire logic i_kick,
	wwr_tick_if.src tk
);
	import wwr_pkg::*;
	logic [PRE_W-1:0] pre_q, pre_d; // Prescaler count
	logic tick_q, tick_d; // Sample tick pulse
	logic [3:0] hist_q, hist_d; // Last four samples, newest in bit 0
	logic trig_q, trig_d; // Valid trigger pulse
	logic [PRE_W-1:0] pre_top; // Prescaler terminal value
	assign pre_top = i_slow ? PRE_W'(SAM_CYCLES * SLOW_MULT - 1)
		: PRE_W'(SAM_CYCLES - 1);
	// Next values: prescaler, sample shift and pattern match
	always_comb begin
		pre_d = pre_q + 1'b1;
		tick_d = 1'b0;
		hist_d = hist_q;
		trig_d = 1'b0;
		if (pre_q >= pre_top) begin
			pre_d = '0;
			tick_d = 1'b1;
			hist_d = {hist_q[2:0], i_kick};
			// High-high-low-low pattern marks a falling edge trigger
			trig_d = ({hist_q[2:0], i_kick} == 4'b1100);
		end
	end
	// Register stage
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pre_q <= '0;
			tick_q <= 1'b0;
			hist_q <= 4'h0;
			trig_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			tick_q <= tick_d;
			hist_q <= hist_d;
			trig_q <= trig_d;
		end
	end
	assign tk.tick = tick_q;
	assign tk.trig = trig_q;
	// Trigger only ever lands on a sample tick
	a_trig_on_tick: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		trig_q |-> tick_q) else $error("trigger outside sample tick");
	// Trigger needs the high-high-low-low history
	a_trig_pattern: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		trig_q |-> hist_q == 4'b1100) else $error("trigger without valid pattern");
endmodule
`default_nettype wire

/* rtl/wwr_top.sv */
// Window watchdog and reset sequencer top
// Behaviour
// - Mode pins select fast, slow or off
// - Both pins low gives fast timing
// - Hold reset low after power-on
// - Reset release starts ignore span
// - Kicks ignored during ignore span
// - Then long first open span, four spans
// - Trigger in long span starts closed span
// - Falling kick edge is the trigger
// - Two high then two low samples
// - Closed span end starts standard open span
// - Trigger in open span starts closed span
// - Open span expiry forces reset low
// - Trigger in closed span forces reset
// - Undervoltage drives reset low
// - Enable switches regulator on or off
// - Slow mode doubles sample and span times
// - Hold time fast only with both low
`timescale 1ns/100ps
`default_nettype none
module wwr_top #(
	// Clock cycles per fast sample period; only a bench shortens it
	parameter int unsigned SAM_CYCLES = wwr_pkg::SAM_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_enable, // Regulator enable pin
	input wire logic i_undervolt, // Comparator: output below threshold
	input wire logic i_wd_mode_sel_1,
	input wire logic i_wd_mode_sel_2,
	input wire logic i_kick_input,
	output logic o_reg_on, // Regulator on
	output logic o_reset_out_b, // Reset to processor, low active
	output wwr_pkg::wwr_state_e o_state // Sequencer state
);
	import wwr_pkg::*;
	// Two-flop synchronisers for pins
	logic [4:0] s1_q, s2_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			s1_q <= 5'h0_0;
			s2_q <= 5'h0_0;
		end else begin
			s1_q <= {i_enable, i_undervolt, i_wd_mode_sel_1, i_wd_mode_sel_2, i_kick_input};
			s2_q <= s1_q;
		end
	end
	logic en_s, uv_s, m1_s, m2_s, kick_s; // Synchronised pins
	assign {en_s, uv_s, m1_s, m2_s, kick_s} = s2_q;
	// Decode mode from pin levels
	function automatic wwr_mode_e mode_of(input logic m1, input logic m2);
		if (!m2)
			return MODE_FAST;
		else if (!m1)
			return MODE_SLOW;
		else
			return MODE_OFF;
	endfunction
	wwr_mode_e mode;
	assign mode = mode_of(m1_s, m2_s);
	logic slow_hold; // Hold time doubled unless both pins low
	assign slow_hold = m1_s | m2_s;
	// Sample timebase and trigger detector
	wwr_tick_if tk ();
	wwr_sampler #(
		.SAM_CYCLES(SAM_CYCLES)
	) u_sampler (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_slow(mode == MODE_SLOW),
		.i_kick(kick_s),
		.tk(tk)
	);
	// Supply good: regulator enabled and above threshold
	logic supply_ok;
	assign supply_ok = en_s & ~uv_s;
	wwr_state_e st_q, st_d; // Sequencer state
	logic [SPAN_W-1:0] cnt_q, cnt_d; // Ticks spent in current state
	logic rst_q, rst_d; // Reset output, low active
	logic reg_q, reg_d; // Regulator on
	logic [SPAN_W-1:0] hold_len, span_len, long_len; // Lengths in ticks
	logic wd_on; // Watchdog armed
	// In slow timing the tick itself is doubled, hold included; other modes double the hold count unless both pins low
	always_comb begin
		hold_len = (slow_hold && mode != MODE_SLOW) ? SPAN_W'(HOLD_TICKS * SLOW_MULT)
			: SPAN_W'(HOLD_TICKS);
		span_len = SPAN_W'(SPAN_TICKS);
		long_len = SPAN_W'(LONG_TICKS);
	end
	assign wd_on = (mode != MODE_OFF);
	// Sequencer next state
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		rst_d = rst_q;
		reg_d = en_s;
		if (!supply_ok) begin
			// Power loss or undervoltage: back to hold
			st_d = ST_HOLD;
			cnt_d = '0;
			rst_d = 1'b0;
		end else if (tk.tick) begin
			cnt_d = cnt_q + 1'b1;
			case (st_q)
				ST_HOLD: begin
					rst_d = 1'b0;
					if (cnt_q + 1'b1 >= hold_len) begin
						st_d = ST_IGNORE;
						cnt_d = '0;
						rst_d = 1'b1;
					end
				end
				ST_IGNORE: begin
					// Kick activity disregarded here
					if (cnt_q + 1'b1 >= span_len) begin
						st_d = wd_on ? ST_LONG_OPEN : ST_IGNORE;
						cnt_d = '0;
					end
				end
				ST_LONG_OPEN, ST_OPEN: begin
					if (tk.trig) begin
						st_d = ST_CLOSED;
						cnt_d = '0;
					end else if (cnt_q + 1'b1 >= ((st_q == ST_OPEN) ? span_len : long_len)) begin
						st_d = ST_HOLD;
						cnt_d = '0;
						rst_d = 1'b0;
					end
				end
				ST_CLOSED: begin
					if (tk.trig) begin
						st_d = ST_HOLD;
						cnt_d = '0;
						rst_d = 1'b0;
					end else if (cnt_q + 1'b1 >= span_len) begin
						st_d = ST_OPEN;
						cnt_d = '0;
					end
				end
				default: begin
					st_d = ST_HOLD;
					cnt_d = '0;
					rst_d = 1'b0;
				end
			endcase
		end
		// Off mode: park in ignore once released, at once and not only on a tick,
		// so that a mode change never leaves a watchdog span running between ticks
		if (supply_ok && !wd_on && st_q != ST_HOLD) begin
			st_d = ST_IGNORE;
			cnt_d = '0;
			rst_d = 1'b1;
		end
	end
	// Sequencer registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			st_q <= ST_HOLD;
			cnt_q <= '0;
			rst_q <= 1'b0;
			reg_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			rst_q <= rst_d;
			reg_q <= reg_d;
		end
	end
	assign o_reset_out_b = rst_q;
	assign o_reg_on = reg_q;
	assign o_state = st_q;
	// Reset low throughout hold
	a_hold_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q == ST_HOLD |-> !rst_q) else $error("reset high during hold");
	// Undervoltage reaches reset within one cycle
	a_uv_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		!supply_ok |=> !rst_q && st_q == ST_HOLD) else $error("undervoltage ignored");
	// Leaving hold releases reset into ignore
	a_release_ign: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q == ST_HOLD ##1 st_q != ST_HOLD |-> st_q == ST_IGNORE && rst_q)
		else $error("release not into ignore");
	// No trigger effect in ignore
	a_ignore_kick: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q == ST_IGNORE && supply_ok && wd_on && cnt_q + 1'b1 < span_len |=> st_q == ST_IGNORE)
		else $error("ignore span cut short");
	// Trigger in open spans starts closed
	a_open_trig: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(st_q == ST_OPEN || st_q == ST_LONG_OPEN) && tk.trig && supply_ok && wd_on
		|=> st_q == ST_CLOSED && cnt_q == 0) else $error("trigger did not close");
	// Premature trigger resets
	a_closed_trig: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q == ST_CLOSED && tk.trig && supply_ok && wd_on |=> st_q == ST_HOLD && !rst_q)
		else $error("early trigger missed");
	// Closed end opens the standard span
	a_closed_end: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q == ST_CLOSED ##1 st_q != ST_CLOSED && rst_q && wd_on |-> st_q == ST_OPEN)
		else $error("closed span end wrong");
	// Open span never outlives its length
	a_open_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q == ST_OPEN |-> cnt_q < span_len) else $error("open span overran");
	// Off mode never enters watchdog spans
	a_off_mode: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		mode == MODE_OFF && $past(mode) == MODE_OFF ##1 1'b1 |-> st_q inside {ST_HOLD, ST_IGNORE})
		else $error("watchdog active in off mode");
endmodule
`default_nettype wire

/* tb/wwr_cpu_model.sv */
// Processor model that issues kick pulses on request
`timescale 1ns/100ps
`default_nettype none
module wwr_cpu_model import wwr_pkg::*; #(
	parameter int unsigned SAM_CYCLES = SAM_CYC // Cycles per fast sample period
) (
	input wire logic i_ref_clk,
	input wire logic i_slow, // Doubled sample period
	input wire logic i_req, // One-cycle pulse request
	output logic o_kick,
	output logic o_done
);
	int cnt; // Cycles into the pulse
	int len; // Length of one level phase
	initial begin
		o_kick = 1'b0;
		o_done = 1'b1;
	end
	// Three periods high, three low: two clean samples each
	always @(posedge i_ref_clk) begin
		len = 3 * SAM_CYCLES * (i_slow ? 2 : 1);
		if (i_req && o_done) begin
			o_done <= 1'b0;
			o_kick <= 1'b1;
			cnt <= 0;
		end else if (!o_done) begin
			cnt <= cnt + 1;
			if (cnt == len) o_kick <= 1'b0;
			if (cnt == 2 * len) o_done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* tb/wwr_top_tb.sv */
// Bench for the window watchdog reset block
`timescale 1ns/100ps
`default_nettype none
module wwr_top_tb;
	import wwr_pkg::*;
	// Shortened sample period keeps the run small; all spans scale with it
	localparam int unsigned TB_SAM = 64;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic en = 1'b1;
	logic uv = 1'b0;
	logic m1 = 1'b0;
	logic m2 = 1'b0;
	logic req = 1'b0;
	logic kick, done, reg_on, ro_b;
	wwr_state_e st;
	int err_count = 0;
	int n_tests = 0;
	always #2 clk = ~clk;
	wwr_top #(.SAM_CYCLES(TB_SAM)) uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_enable(en),
		.i_undervolt(uv),
		.i_wd_mode_sel_1(m1), .i_wd_mode_sel_2(m2), .i_kick_input(kick),
		.o_reg_on(reg_on), .o_reset_out_b(ro_b), .o_state(st));
	wwr_cpu_model #(.SAM_CYCLES(TB_SAM)) cpu (.i_ref_clk(clk), .i_slow(m2 & ~m1),
		.i_req(req), .o_kick(kick),
		.o_done(done));
	task automatic chk(string nm, logic [3:0] got, logic [3:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Wait whole fast sample periods
	task automatic ticks(int n);
		repeat (n * TB_SAM) @(posedge clk);
	endtask
	// One kick pulse, returns after its low phase
	task automatic pulse();
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 14 * TB_SAM && !done; i++) @(posedge clk);
	endtask
	// Look once outputs have settled, then realign to the next rising edge
	task automatic ck(logic r, wwr_state_e s);
		#1;
		chk("reset_out_b", {3'h0, ro_b}, {3'h0, r});
		chk("state", {1'b0, st}, {1'b0, s});
		@(posedge clk);
	endtask
	task automatic t_power_on();
		ticks(31);
		ck(1'b0, ST_HOLD);
		ticks(2);
		ck(1'b1, ST_IGNORE);
		pulse();
		pulse();
		ticks(40);
		ck(1'b1, ST_IGNORE);
		ticks(14);
		ck(1'b1, ST_LONG_OPEN);
		$display("test power_on done");
	endtask
	task automatic t_windows();
		ticks(20);
		pulse();
		ck(1'b1, ST_CLOSED);
		ticks(56);
		ck(1'b1, ST_CLOSED);
		ticks(10);
		ck(1'b1, ST_OPEN);
		ticks(24);
		pulse();
		ck(1'b1, ST_CLOSED);
		ticks(4);
		pulse();
		ck(1'b0, ST_HOLD);
		ticks(29);
		ck(1'b0, ST_HOLD);
		ticks(4);
		ck(1'b1, ST_IGNORE);
		ticks(66);
		pulse();
		ticks(124);
		ck(1'b1, ST_OPEN);
		ticks(6);
		ck(1'b0, ST_HOLD);
		$display("test windows done");
	endtask
	task automatic t_supply();
		ticks(34);
		uv <= 1'b1;
		repeat (8) @(posedge clk);
		ck(1'b0, ST_HOLD);
		en <= 1'b0;
		repeat (8) @(posedge clk);
		chk("reg_on", {3'h0, reg_on}, 4'h0);
		en <= 1'b1;
		m2 <= 1'b1;
		repeat (8) @(posedge clk);
		chk("reg_on", {3'h0, reg_on}, 4'h1);
		uv <= 1'b0;
		ticks(62);
		ck(1'b0, ST_HOLD);
		ticks(4);
		ck(1'b1, ST_IGNORE);
		ticks(122);
		ck(1'b1, ST_IGNORE);
		ticks(8);
		ck(1'b1, ST_LONG_OPEN);
		pulse();
		ck(1'b1, ST_CLOSED);
		$display("test supply done");
	endtask
	task automatic t_off();
		uv <= 1'b1;
		m1 <= 1'b1;
		repeat (8) @(posedge clk);
		uv <= 1'b0;
		ticks(62);
		ck(1'b0, ST_HOLD);
		ticks(204);
		pulse();
		ck(1'b1, ST_IGNORE);
		$display("test off done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_power_on();
		t_windows();
		t_supply();
		t_off();
		end_sim();
	end
	// Hang guard, well beyond the planned sample periods
	initial begin
		repeat (1300 * TB_SAM) @(posedge clk);
		err_count++;
		end_sim();
	end
endmodule
`default_nettype wire
